// *** rtl/monitor_pkg.sv ***
package monitor_pkg;

   // widths and counts
   localparam int PV_W          = 24;
   localparam int NCH           = 4;
   localparam int DISC_W        = 13;
   localparam int PER_W         = 6;

   // timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int MS_NS         = 1000000;
   localparam int MS_CYCLES_DEF = MS_NS / CLK_PERIOD_NS;

   localparam logic [PER_W-1:0] PERIOD_FINE_MS   = PER_W'(60);
   localparam logic [PER_W-1:0] PERIOD_MID_MS    = PER_W'(10);
   localparam logic [PER_W-1:0] PERIOD_COARSE_MS = PER_W'(5);

   localparam logic [DISC_W-1:0] DISC_RTD4_MS  = DISC_W'(5000);
   localparam logic [DISC_W-1:0] DISC_MV_MS    = DISC_W'(1000);
   localparam logic [DISC_W-1:0] DISC_OTHER_MS = DISC_W'(500);

   // value scale: 0 is 0 %, SPAN_INT is 100 % of the range
   localparam int SPAN_INT = 1048576;
   localparam logic signed [PV_W-1:0] LIM_P115  = PV_W'(SPAN_INT * 115 / 100);
   localparam logic signed [PV_W-1:0] LIM_M15   = PV_W'(-(SPAN_INT * 15 / 100));
   localparam logic signed [PV_W-1:0] LIM_P1075 = PV_W'(SPAN_INT * 1075 / 1000);
   localparam logic signed [PV_W-1:0] LIM_M75   = PV_W'(-(SPAN_INT * 75 / 1000));
   localparam logic signed [PV_W-1:0] PV_ZERO   = PV_W'(0);
   localparam logic signed [PV_W-1:0] PV_MID    = PV_W'(SPAN_INT / 2);

   typedef enum logic [3:0] {
      RNG_RTD_3W    = 4'b0000,
      RNG_RTD_4W    = 4'b0001,
      RNG_TC        = 4'b0010,
      RNG_MV_USER   = 4'b0011,
      RNG_POT       = 4'b0100,
      RNG_MA_4_20   = 4'b0101,
      RNG_V_1_5     = 4'b0110,
      RNG_V_0_1P25  = 4'b0111,
      RNG_V_0_5     = 4'b1000,
      RNG_V_0_10    = 4'b1001,
      RNG_MA_0_20   = 4'b1010,
      RNG_V_PM1P25  = 4'b1011,
      RNG_V_PM5     = 4'b1100,
      RNG_V_PM10    = 4'b1101,
      RNG_V_PM10_US = 4'b1110
   } range_t;

   typedef enum logic [1:0] {
      RES_FINE   = 2'b00,
      RES_MID    = 2'b01,
      RES_COARSE = 2'b10
   } res_t;

   typedef struct packed {
      logic [1:0]             chan;
      logic signed [PV_W-1:0] data;
   } sample_t;

   // register byte addresses
   localparam logic [7:0] ADDR_CTRL     = 8'h00;
   localparam logic [7:0] ADDR_RANGE    = 8'h04;
   localparam logic [7:0] ADDR_STATUS   = 8'h08;
   localparam logic [7:0] ADDR_PV0      = 8'h0C;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h1C;
   localparam logic [7:0] ADDR_IRQ_CLR  = 8'h20;
   localparam logic [7:0] ADDR_IRQ_EN   = 8'h24;

   // reset values
   localparam logic [8:0]  CTRL_RST   = 9'h000;
   localparam logic [15:0] RANGE_RST  = 16'h0000;
   localparam logic [4:0]  IRQ_EN_RST = 5'h00;

   // field positions
   localparam int CTRL_RES_LSB   = 0;
   localparam int CTRL_CLAMP_LSB = 4;
   localparam int CTRL_RUN_BIT   = 8;
   localparam int STAT_DISC_LSB  = 4;
   localparam int IRQ_DONE_BIT   = 0;
   localparam int IRQ_FAULT_LSB  = 1;

endpackage

// *** rtl/chan_check.sv ***
`timescale 1ns/1ps
`default_nettype none
module chan_check
   import monitor_pkg::*;
(
   input  wire logic                   mclk,
   input  wire logic                   nrst,
   input  wire logic                   ms_tick,
   input  wire range_t                 range_sel,
   input  wire logic                   clamp_high,
   input  wire logic                   open_pin,
   input  wire logic                   sample_valid,
   input  wire logic signed [PV_W-1:0] sample_data,
   output logic                        fault,
   output logic                        disc,
   output logic signed [PV_W-1:0]      pv
);

   logic                   open_meta;
   logic                   open_sync;
   logic [DISC_W-1:0]      disc_cnt;
   logic [DISC_W-1:0]      next_disc_cnt;
   logic                   next_disc;
   logic                   next_fault;
   logic signed [PV_W-1:0] next_pv;
   logic [DISC_W-1:0]      disc_limit;
   logic                   temp_cls;
   logic                   uni_clamp;
   logic                   uni_zero;
   logic                   ma020;
   logic                   bip;
   logic signed [PV_W-1:0] hi_lim;
   logic signed [PV_W-1:0] lo_lim;
   logic                   over;
   logic                   under;

   always_comb begin
      temp_cls  = (range_sel <= RNG_POT);
      uni_clamp = (range_sel == RNG_MA_4_20) || (range_sel == RNG_V_1_5);
      uni_zero  = (range_sel >= RNG_V_0_1P25) && (range_sel <= RNG_V_0_10);
      ma020     = (range_sel == RNG_MA_0_20);
      bip       = (range_sel >= RNG_V_PM1P25);
      hi_lim    = bip ? LIM_P1075 : LIM_P115;
      lo_lim    = bip ? LIM_M75 : LIM_M15;
      over      = (sample_data > hi_lim);
      under     = (sample_data < lo_lim) && !ma020;
      if (range_sel == RNG_RTD_4W) begin
         disc_limit = DISC_RTD4_MS;
      end else if (range_sel == RNG_MV_USER) begin
         disc_limit = DISC_MV_MS;
      end else begin
         disc_limit = DISC_OTHER_MS;
      end
   end

   // open-wire debounce and sample evaluation
   always_comb begin
      next_disc_cnt = disc_cnt;
      next_fault    = fault;
      next_pv       = pv;
      if (!open_sync) begin
         next_disc_cnt = '0;
      end else if (ms_tick && disc_cnt < disc_limit) begin
         next_disc_cnt = disc_cnt + DISC_W'(1);
      end
      next_disc = open_sync && (next_disc_cnt >= disc_limit);
      if (sample_valid) begin
         // flag recomputed each sample, so it clears once healthy
         next_fault = over || under ||
                      (disc && (temp_cls || uni_clamp || uni_zero));
         next_pv    = sample_data;
         if (disc) begin
            if (temp_cls) begin
               next_pv = clamp_high ? LIM_P115 : LIM_M15;
            end else if (uni_clamp) begin
               next_pv = LIM_M15;
            end else if (uni_zero || ma020) begin
               next_pv = PV_ZERO;
            end else begin
               next_pv = PV_MID;
            end
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         open_meta <= 1'b0;
         open_sync <= 1'b0;
         disc_cnt  <= '0;
         disc      <= 1'b0;
         fault     <= 1'b0;
         pv        <= PV_ZERO;
      end else begin
         open_meta <= open_pin;
         open_sync <= open_meta;
         disc_cnt  <= next_disc_cnt;
         disc      <= next_disc;
         fault     <= next_fault;
         pv        <= next_pv;
      end
   end

   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);

   chk_disc_time: assert property (
      $rose(disc) |-> open_sync && disc_cnt >= disc_limit)
      else $error("disconnect flagged before its detection time");

   chk_disc_drop: assert property (
      !open_sync |=> !disc)
      else $error("disconnect held after wire restored");

   chk_temp_fault: assert property (
      sample_valid && disc && temp_cls |=> fault)
      else $error("temperature input disconnect not flagged");

   chk_temp_clamp: assert property (
      sample_valid && disc && temp_cls |=>
      pv == ($past(clamp_high) ? LIM_P115 : LIM_M15))
      else $error("wrong clamp value on disconnect");

   chk_uni_band: assert property (
      sample_valid && (uni_clamp || uni_zero) &&
      (sample_data < LIM_M15 || sample_data > LIM_P115) |=> fault)
      else $error("unipolar out-of-band not flagged");

   chk_uni_clamp: assert property (
      sample_valid && disc && uni_clamp |=> pv == LIM_M15)
      else $error("live-zero range disconnect value wrong");

   chk_uni_zero: assert property (
      sample_valid && disc && uni_zero |=> pv == PV_ZERO)
      else $error("voltage range disconnect value wrong");

   chk_ma020_low: assert property (
      sample_valid && ma020 && !disc && sample_data <= LIM_P115 |=> !fault)
      else $error("low check applied on 0-20 mA");

   chk_ma020_zero: assert property (
      sample_valid && ma020 && disc |=> pv == PV_ZERO)
      else $error("0-20 mA disconnect value wrong");

   chk_bip_band: assert property (
      sample_valid && bip &&
      (sample_data > LIM_P1075 || sample_data < LIM_M75) |=> fault)
      else $error("bipolar out-of-band not flagged");

   chk_bip_zero: assert property (
      sample_valid && bip && disc |=> pv == PV_MID)
      else $error("bipolar disconnect value wrong");

   chk_store_value: assert property (
      sample_valid && !disc |=> pv == $past(sample_data))
      else $error("converted value not stored");

   chk_fault_clear: assert property (
      sample_valid && !disc && !over && !under |=> !fault)
      else $error("fault flag stuck while healthy");

endmodule
`default_nettype wire

// *** rtl/input_range_error_monitor.sv ***
// How it works
// - all four inputs converted each period: 60, 10 or 5 ms by resolution
// - new value readable within one period plus one host scan
// - temperature, mV, pot inputs: fault on open wire or outside -15..115 %
// - those inputs store 115 % or -15 % on open wire, by clamp setting
// - open wire found in about 5 s, 1 s or 0.5 s by input type
// - unipolar voltage and 4-20 mA ranges: fault on open wire or band exit
// - 4-20 mA and 1-5 V store -15 % on open wire
// - other unipolar voltage ranges store the 0 V value on open wire
// - 0-20 mA flags only above 115 %, no low check
// - 0-20 mA stores the 0 mA value on open wire
// - bipolar ranges flag outside -7.5 .. 107.5 %
// - bipolar ranges store the 0 V value on open wire
`timescale 1ns/1ps
`default_nettype none
module input_range_error_monitor
   import monitor_pkg::*;
#(
   parameter int MS_CYCLES = MS_CYCLES_DEF
)(
   input  wire logic            mclk,
   input  wire logic            nrst,
   input  wire logic            psel,
   input  wire logic            penable,
   input  wire logic            pwrite,
   input  wire logic [7:0]      paddr,
   input  wire logic [31:0]     pwdata,
   output logic [31:0]          prdata,
   output logic                 pready,
   output logic                 pslverr,
   output logic                 conv_start,
   input  wire logic            sample_valid,
   input  wire sample_t         sample,
   input  wire logic [NCH-1:0]  open_pin,
   output logic                 irq
);

   localparam int MS_W = $clog2(MS_CYCLES + 1);

   logic [8:0]             ctrl;
   logic [8:0]             next_ctrl;
   logic [15:0]            range_cfg;
   logic [15:0]            next_range_cfg;
   logic [4:0]             irq_en;
   logic [4:0]             next_irq_en;
   logic [4:0]             irq_stat;
   logic [4:0]             next_irq_stat;
   logic [31:0]            next_prdata;
   logic                   next_pslverr;
   logic                   next_irq;
   logic [MS_W-1:0]        ms_cnt;
   logic [MS_W-1:0]        next_ms_cnt;
   logic                   ms_tick;
   logic                   next_ms_tick;
   logic [PER_W-1:0]       period_cnt;
   logic [PER_W-1:0]       next_period_cnt;
   logic [PER_W-1:0]       period_len;
   logic                   next_conv_start;
   logic [NCH-1:0]         fault;
   logic [NCH-1:0]         fault_d;
   logic [NCH-1:0]         disc;
   logic signed [PV_W-1:0] pv [NCH];
   logic [4:0]             events;
   logic                   setup;
   logic                   wr_en;
   logic [3:0]             clamp_high;

   assign clamp_high = ctrl[CTRL_CLAMP_LSB +: NCH];

   // per-channel fault checking
   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : gen_ch
         chan_check u_chk (
            .mclk         (mclk),
            .nrst         (nrst),
            .ms_tick      (ms_tick),
            .range_sel    (range_t'(range_cfg[4*g +: 4])),
            .clamp_high   (clamp_high[g]),
            .open_pin     (open_pin[g]),
            .sample_valid (sample_valid && sample.chan == 2'(g)),
            .sample_data  (sample.data),
            .fault        (fault[g]),
            .disc         (disc[g]),
            .pv           (pv[g])
         );
      end
   endgenerate

   // conversion period select
   always_comb begin
      unique case (res_t'(ctrl[CTRL_RES_LSB +: 2]))
         RES_MID:    period_len = PERIOD_MID_MS;
         RES_COARSE: period_len = PERIOD_COARSE_MS;
         default:    period_len = PERIOD_FINE_MS;
      endcase
   end

   // ms divider and period timer
   always_comb begin
      next_ms_cnt     = ms_cnt + MS_W'(1);
      next_ms_tick    = 1'b0;
      next_period_cnt = period_cnt;
      next_conv_start = 1'b0;
      if (ms_cnt == MS_W'(MS_CYCLES - 1)) begin
         next_ms_cnt  = '0;
         next_ms_tick = 1'b1;
      end
      if (!ctrl[CTRL_RUN_BIT]) begin
         next_period_cnt = '0;
      end else if (ms_tick) begin
         if (period_cnt == '0) begin
            next_period_cnt = period_len - PER_W'(1);
            next_conv_start = 1'b1;
         end else begin
            next_period_cnt = period_cnt - PER_W'(1);
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         ms_cnt     <= '0;
         ms_tick    <= 1'b0;
         period_cnt <= '0;
         conv_start <= 1'b0;
      end else begin
         ms_cnt     <= next_ms_cnt;
         ms_tick    <= next_ms_tick;
         period_cnt <= next_period_cnt;
         conv_start <= next_conv_start;
      end
   end

   // apb slave, zero wait states; read data captured in setup
   assign setup  = psel && !penable;
   assign wr_en  = psel && penable && pwrite;
   assign pready = psel && penable;
   assign events = {fault & ~fault_d, conv_start};

   always_comb begin
      next_ctrl      = ctrl;
      next_range_cfg = range_cfg;
      next_prdata    = prdata;
      next_pslverr   = pslverr;
      if (setup) begin
         next_prdata  = 32'h0000_0000;
         next_pslverr = 1'b0;
         unique case (paddr)
            ADDR_CTRL:     next_prdata = 32'(ctrl);
            ADDR_RANGE:    next_prdata = 32'(range_cfg);
            ADDR_STATUS:   next_prdata = 32'({disc, fault});
            ADDR_PV0,
            ADDR_PV0 + 8'h04,
            ADDR_PV0 + 8'h08,
            ADDR_PV0 + 8'h0C:
               next_prdata = 32'(pv[2'((paddr - ADDR_PV0) >> 2)]);
            ADDR_IRQ_STAT: next_prdata = 32'(irq_stat);
            ADDR_IRQ_CLR:  next_prdata = 32'h0000_0000;
            ADDR_IRQ_EN:   next_prdata = 32'(irq_en);
            default:       next_pslverr = 1'b1;
         endcase
      end
      if (wr_en) begin
         unique case (paddr)
            ADDR_CTRL:    next_ctrl      = pwdata[8:0];
            ADDR_RANGE:   next_range_cfg = pwdata[15:0];
            default:      next_ctrl      = ctrl;
         endcase
      end
   end

   // sticky interrupt status, clear and enable
   always_comb begin
      next_irq_stat = irq_stat | events;
      next_irq_en   = irq_en;
      if (wr_en && paddr == ADDR_IRQ_CLR) begin
         // an event in the clear cycle survives the clear
         next_irq_stat = (irq_stat & ~pwdata[4:0]) | events;
      end
      if (wr_en && paddr == ADDR_IRQ_EN) begin
         next_irq_en = pwdata[4:0];
      end
      next_irq = |(next_irq_stat & next_irq_en);
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         ctrl      <= CTRL_RST;
         range_cfg <= RANGE_RST;
         prdata    <= 32'h0000_0000;
         pslverr   <= 1'b0;
      end else begin
         ctrl      <= next_ctrl;
         range_cfg <= next_range_cfg;
         prdata    <= next_prdata;
         pslverr   <= next_pslverr;
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         irq_en   <= IRQ_EN_RST;
         irq_stat <= '0;
         irq      <= 1'b0;
         fault_d  <= '0;
      end else begin
         irq_en   <= next_irq_en;
         irq_stat <= next_irq_stat;
         irq      <= next_irq;
         fault_d  <= fault;
      end
   end

   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);

   chk_period_reload: assert property (
      conv_start |-> period_cnt == $past(period_len) - PER_W'(1))
      else $error("conversion period reload wrong");

   chk_period_gap: assert property (
      ctrl[CTRL_RUN_BIT] && ms_tick && period_cnt != '0 |=> !conv_start)
      else $error("conversion started mid period");

   chk_pv_read: assert property (
      setup && paddr == ADDR_PV0 |=> prdata == 32'($past(pv[0])))
      else $error("stored value not returned to host");

   // period timer checks
   chk_run_off: assert property (
      !ctrl[CTRL_RUN_BIT] |=> !conv_start)
      else $error("conversion started while stopped");

   chk_start_tick: assert property (
      conv_start |-> $past(ms_tick))
      else $error("conversion start off the ms tick");

   chk_start_pulse: assert property (
      conv_start |=> !conv_start)
      else $error("conversion start longer than a cycle");

   chk_tick_pulse: assert property (
      ms_tick |=> !ms_tick)
      else $error("ms tick longer than a cycle");

   chk_period_hold: assert property (
      ctrl[CTRL_RUN_BIT] && !ms_tick |=> $stable(period_cnt))
      else $error("period timer moved without a tick");

   // register bus checks
   chk_stat_read: assert property (
      setup && paddr == ADDR_STATUS |=> prdata == 32'($past({disc, fault})))
      else $error("status not returned to host");

   chk_pv3_read: assert property (
      setup && paddr == ADDR_PV0 + 8'h0C |=> prdata == 32'($past(pv[3])))
      else $error("last stored value not returned");

   chk_bad_addr: assert property (
      setup && paddr > ADDR_IRQ_EN |=> pslverr)
      else $error("unmapped access not refused");

   chk_good_addr: assert property (
      setup && paddr <= ADDR_IRQ_EN && paddr[1:0] == 2'b00 |=> !pslverr)
      else $error("mapped access refused");

   chk_ctrl_write: assert property (
      wr_en && paddr == ADDR_CTRL |=> ctrl == $past(pwdata[8:0]))
      else $error("control write lost");

   chk_ro_status: assert property (
      wr_en && paddr == ADDR_STATUS |=> $stable(range_cfg))
      else $error("status write changed the range setting");

   chk_range_write: assert property (
      wr_en && paddr == ADDR_RANGE |=> range_cfg == $past(pwdata[15:0]))
      else $error("range write lost");

   // interrupt checks
   chk_done_event: assert property (
      conv_start |=> irq_stat[IRQ_DONE_BIT])
      else $error("conversion event not latched");

   chk_fault_event: assert property (
      fault[0] && !fault_d[0] |=> irq_stat[IRQ_FAULT_LSB])
      else $error("fault event not latched");

   chk_clear_bit: assert property (
      wr_en && paddr == ADDR_IRQ_CLR && pwdata[0] && !conv_start |=>
      !irq_stat[IRQ_DONE_BIT])
      else $error("interrupt status not cleared");

   chk_sticky_bit: assert property (
      irq_stat[IRQ_DONE_BIT] && !(wr_en && paddr == ADDR_IRQ_CLR) |=>
      irq_stat[IRQ_DONE_BIT])
      else $error("interrupt status lost without clear");

   chk_en_write: assert property (
      wr_en && paddr == ADDR_IRQ_EN |=> irq_en == $past(pwdata[4:0]))
      else $error("interrupt enable write lost");

   chk_irq_level: assert property (
      irq == |(irq_stat & irq_en))
      else $error("interrupt line disagrees with status");

endmodule
`default_nettype wire

// *** sim/front_end_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module front_end_model
   import monitor_pkg::*;
(
   input  wire logic mclk,
   input  wire logic nrst,
   input  wire logic conv_start,
   output logic      sample_valid,
   output sample_t   sample
);
   logic signed [PV_W-1:0] val [NCH];
   int                     gap = 0;
   int                     left = 0;
   int                     wait_n = 0;

   initial begin
      for (int i = 0; i < NCH; i++) begin
         val[i] = PV_MID;
      end
   end

   // one sample per input after each start, optionally spaced by gap
   always @(posedge mclk) begin
      if (nrst && left > 0 && wait_n >= gap && !conv_start) begin
         sample_valid <= 1'b1;
         sample       <= {2'(NCH - left), val[NCH - left]};
         left         = left - 1;
         wait_n       = 0;
      end else begin
         sample_valid <= 1'b0;
         sample       <= ~sample;
         wait_n       = wait_n + 1;
         if (!nrst) begin
            left = 0;
         end else if (conv_start) begin
            left   = NCH;
            wait_n = 0;
         end
      end
   end
endmodule
`default_nettype wire

// *** sim/test_input_range_error_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_input_range_error_monitor
   import monitor_pkg::*;
;
   localparam int MSC = 10;
   logic           mclk = 1'b0;
   logic           nrst = 1'b0;
   logic           psel = 1'b0;
   logic           penable = 1'b0;
   logic           pwrite = 1'b0;
   logic [7:0]     paddr = 8'h00;
   logic [31:0]    pwdata = 32'h0000_0000;
   logic [NCH-1:0] open_pin = 4'h0;
   logic [31:0]    prdata;
   logic           pready;
   logic           pslverr;
   logic           conv_start;
   logic           sample_valid;
   logic           irq;
   sample_t        sample;
   int             error_cnt = 0;
   int             total_checks = 0;
   int             cyc = 0;
   logic [32:0]    exp_q[$];
   logic [32:0]    msk_q[$];
   string          name_q[$];

   always #5 mclk = ~mclk;
   always @(posedge mclk) cyc <= cyc + 1;

   input_range_error_monitor #(.MS_CYCLES(MSC)) u_dut (
      .mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .conv_start(conv_start),
      .sample_valid(sample_valid), .sample(sample), .open_pin(open_pin),
      .irq(irq));

   front_end_model u_fe (.mclk(mclk), .nrst(nrst), .conv_start(conv_start),
      .sample_valid(sample_valid), .sample(sample));

   task automatic final_report;
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [32:0] seen,
                      input logic [32:0] e, input logic [32:0] m = '1);
      total_checks++;
      if ((seen & m) !== (e & m)) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", nm, e & m, seen & m);
      end
   endtask

   task automatic timeout(input string nm);
      error_cnt++;
      $display("mismatch %s expected answer seen none", nm);
      final_report();
   endtask

   // watcher: each completed read takes the oldest note
   always @(posedge mclk) begin
      if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1
          && pwrite === 1'b0) begin
         if (exp_q.size() == 0) begin
            chk("unexpected read", 33'h1, 33'h0);
         end else begin
            chk(name_q.pop_front(), {pslverr, prdata}, exp_q.pop_front(),
                msk_q.pop_front());
         end
      end
   end

   task automatic apb(input logic [7:0] a, input logic w,
                      input logic [31:0] d);
      int n;
      n = 0;
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) timeout("pready");
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask

   task automatic rd(input string nm, input logic [7:0] a,
                     input logic [32:0] e, input logic [32:0] m = '1);
      exp_q.push_back(e);
      msk_q.push_back(m);
      name_q.push_back(nm);
      apb(a, 1'b0, 32'h0000_0000);
   endtask

   task automatic wait_conv(output int n);
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (conv_start !== 1'b1 && n < 2000);
      if (conv_start !== 1'b1) timeout("conv_start");
   endtask

   task automatic wait_ms(input int t0, input int ms);
      while (cyc < t0 + ms * MSC) @(posedge mclk);
   endtask

   function automatic logic [32:0] pvx(input logic signed [PV_W-1:0] v);
      return {1'b0, {(32 - PV_W){v[PV_W-1]}}, v};
   endfunction

   function automatic logic exp_fault(input range_t r,
                                      input logic signed [PV_W-1:0] v);
      if (r == RNG_MA_0_20) return v > LIM_P115;
      if (r >= RNG_V_PM1P25) return v > LIM_P1075 || v < LIM_M75;
      return v > LIM_P115 || v < LIM_M15;
   endfunction

   initial begin
      int                     n;
      int                     t0;
      logic signed [PV_W-1:0] v;
      logic signed [PV_W-1:0] pv_e [NCH];
      logic signed [PV_W-1:0] tbl [10];
      logic [3:0]             f;
      range_t                 rg [NCH];
      tbl = '{LIM_P115, LIM_P115 + 1, LIM_M15, LIM_M15 - 1, LIM_P1075,
              LIM_P1075 + 1, LIM_M75, LIM_M75 - 1, PV_ZERO - 1, PV_MID};
      n = $urandom(41934);
      repeat (5) @(posedge mclk);
      nrst <= 1'b1;
      rd("ctrl", ADDR_CTRL, 33'(CTRL_RST));
      rd("range", ADDR_RANGE, 33'(RANGE_RST));
      rd("irq_en", ADDR_IRQ_EN, 33'(IRQ_EN_RST));
      rd("unmapped", 8'h30, 33'h1_0000_0000);
      apb(ADDR_STATUS, 1'b1, 32'hFFFF_FFFF);
      rd("status", ADDR_STATUS, 33'h0);
      for (int r = 0; r < 4; r++) begin
         apb(ADDR_CTRL, 1'b1, 32'h0000_0100 | 32'(r));
         repeat (3) wait_conv(n);
         chk("period", 33'(n), 33'(MSC * (r == 1 ? PERIOD_MID_MS :
             r == 2 ? PERIOD_COARSE_MS : PERIOD_FINE_MS)));
      end
      apb(ADDR_CTRL, 1'b1, 32'h0000_0102);
      apb(ADDR_IRQ_EN, 1'b1, 32'h0000_0001);
      wait_conv(n);
      repeat (3) @(posedge mclk);
      chk("irq raised", 33'(irq), 33'h1);
      apb(ADDR_IRQ_EN, 1'b1, 32'h0000_0000);
      chk("irq masked", 33'(irq), 33'h0);
      apb(ADDR_CTRL, 1'b1, 32'h0000_0002);
      rd("irq_stat", ADDR_IRQ_STAT, 33'h1, 33'h1);
      apb(ADDR_IRQ_CLR, 1'b1, 32'h0000_001F);
      rd("irq_stat clr", ADDR_IRQ_STAT, 33'h0, 33'h1);
      apb(ADDR_CTRL, 1'b1, 32'h0000_0102);
      for (int r = 0; r < 15; r++) begin
         for (int k = 0; k < NCH; k++) rg[k] = range_t'(4'((r + k) % 15));
         apb(ADDR_RANGE, 1'b1, {16'h0000, rg[3], rg[2], rg[1], rg[0]});
         for (int it = 0; it < 3; it++) begin
            for (int k = 0; k < NCH; k++) begin
               if ($urandom_range(1)) v = tbl[$urandom_range(9)];
               else v = PV_W'($urandom_range(SPAN_INT * 7 / 5) - SPAN_INT / 5);
               u_fe.val[k] <= v;
               pv_e[k] = v;
               f[k] = exp_fault(rg[k], v);
            end
            u_fe.gap <= int'($urandom_range(2));
            wait_conv(n);
            repeat (15) @(posedge mclk);
            rd("fault", ADDR_STATUS, 33'(f));
            for (int k = 0; k < NCH; k++) begin
               rd("pv", ADDR_PV0 + 8'(4 * k), pvx(pv_e[k]));
            end
         end
      end
      for (int k = 0; k < NCH; k++) u_fe.val[k] <= PV_MID;
      apb(ADDR_RANGE, 1'b1, 32'h0000_5231);
      apb(ADDR_CTRL, 1'b1, 32'h0000_0132);
      open_pin <= 4'hF;
      t0 = cyc;
      wait_ms(t0, 480);
      rd("open early", ADDR_STATUS, 33'h0);
      wait_ms(t0, 520);
      rd("open other", ADDR_STATUS, 33'h0CC);
      rd("clamp low", ADDR_PV0 + 8'h08, pvx(LIM_M15));
      rd("open 4-20", ADDR_PV0 + 8'h0C, pvx(LIM_M15));
      wait_ms(t0, 1020);
      rd("open mv", ADDR_STATUS, 33'h0EE);
      rd("clamp high", ADDR_PV0 + 8'h04, pvx(LIM_P115));
      wait_ms(t0, 4980);
      rd("open 4w early", ADDR_STATUS, 33'h0EE);
      wait_ms(t0, 5020);
      rd("open 4w", ADDR_STATUS, 33'h0FF);
      rd("clamp 4w", ADDR_PV0, pvx(LIM_P115));
      open_pin <= 4'h0;
      repeat (100) @(posedge mclk);
      rd("restored", ADDR_STATUS, 33'h0);
      apb(ADDR_RANGE, 1'b1, 32'h0000_CA84);
      apb(ADDR_CTRL, 1'b1, 32'h0000_0102);
      open_pin <= 4'hF;
      t0 = cyc;
      wait_ms(t0, 520);
      rd("open mixed", ADDR_STATUS, 33'h0F3);
      rd("pot low", ADDR_PV0, pvx(LIM_M15));
      rd("open 0-5v", ADDR_PV0 + 8'h04, pvx(PV_ZERO));
      rd("open 0-20ma", ADDR_PV0 + 8'h08, pvx(PV_ZERO));
      rd("open bipolar", ADDR_PV0 + 8'h0C, pvx(PV_MID));
      chk("reads answered", 33'(exp_q.size()), 33'h0);
      final_report();
   end
endmodule
`default_nettype wire
